//--- pkg/dtrd_pkg.sv
// Shared constants of the serial video link: timing, character codes, sync detect
package dtrd_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int SYS_CLK_NS = 4;
	localparam int BIT_TIME_NS = 16;
	localparam int CYC_PER_BIT = (BIT_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int BITS_PER_CHAR = 10;
	localparam int CYC_PER_PIX = CYC_PER_BIT * BITS_PER_CHAR;
	localparam int OVERSAMPLE = 4;
	localparam int BLANK_MIN_PIX = 128;
	localparam int IDLE_PIX = 1000000;
	localparam int ACQ_PIX = 1600;

	// ---------------------------------------------------------------
	// Control characters, indexed by {c1, c0}
	// ---------------------------------------------------------------
	localparam logic [9:0] TOK_00 = 10'h354;
	localparam logic [9:0] TOK_01 = 10'h0AB;
	localparam logic [9:0] TOK_10 = 10'h154;
	localparam logic [9:0] TOK_11 = 10'h2AB;

endpackage

//--- pkg/dtrd_link_if.sv
// Serial link between the transmitter end and the receiver end
`timescale 1ns/100ps
`default_nettype none
interface dtrd_link_if;
	logic input_reference_clock;
	logic red_lane_input;
	logic green_lane_input;
	logic blue_lane_input;

	modport tx (
		output input_reference_clock,
		output red_lane_input,
		output green_lane_input,
		output blue_lane_input
	);

	modport rx (
		input input_reference_clock,
		input red_lane_input,
		input green_lane_input,
		input blue_lane_input
	);
endinterface
`default_nettype wire

//--- verilog/dtrd_tx_end.sv
// Transmitting end: character encoder, serializer and reference clock divider
`timescale 1ns/100ps
`default_nettype none
module dtrd_tx_end (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic [23:0] i_pixel_rgb, // Red 23:16, green 15:8, blue 7:0
	input wire logic i_de, // Active display request
	input wire logic i_hsync, // Horizontal sync
	input wire logic i_vsync, // Vertical sync
	input wire logic [3:0] i_user_control_bits, // User control bits
	output logic o_take, // Pulse: inputs taken this cycle
	dtrd_link_if.tx link // Serial link
);
	localparam logic [5:0] LAST_CYC = 6'(dtrd_pkg::CYC_PER_PIX - 1);
	localparam logic [5:0] HALF_CYC = 6'(dtrd_pkg::CYC_PER_PIX / 2);
	localparam logic [7:0] BLANK_MIN = 8'(dtrd_pkg::BLANK_MIN_PIX);

	logic [5:0] cyc;
	logic [3:0] bit_idx;
	logic [1:0] bit_cyc;
	logic [9:0] chr [3];
	logic signed [4:0] disp [3];
	logic [7:0] blank_cnt;
	logic de_sent;
	logic eff_de;
	logic [14:0] enc [3];

	// Pick the character with fewer transitions and steer toward DC balance
	function automatic logic [14:0] encode(input logic [7:0] d, input logic signed [4:0] cnt);
		logic [8:0] qm;
		logic [9:0] q;
		logic use_xnor;
		logic signed [4:0] n1;
		logic signed [4:0] n1q;
		logic signed [4:0] diff;
		logic signed [4:0] c;
		n1 = 5'($countones(d));
		use_xnor = (n1 > 5'sd4) || (n1 == 5'sd4 && !d[0]);
		qm[0] = d[0];
		for (int i = 1; i < 8; i++) begin
			qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
		end
		qm[8] = ~use_xnor;
		n1q = 5'($countones(qm[7:0]));
		diff = 5'(n1q + n1q - 5'sd8);
		if (cnt == 5'sd0 || diff == 5'sd0) begin
			q = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
			c = qm[8] ? 5'(cnt + diff) : 5'(cnt - diff);
		end else if ((cnt > 5'sd0 && diff > 5'sd0) || (cnt < 5'sd0 && diff < 5'sd0)) begin
			q = {1'b1, qm[8], ~qm[7:0]};
			c = 5'(cnt + (qm[8] ? 5'sd2 : 5'sd0) - diff);
		end else begin
			q = {1'b0, qm[8], qm[7:0]};
			c = 5'(cnt - (qm[8] ? 5'sd0 : 5'sd2) + diff);
		end
		return {c, q};
	endfunction

	// Control pair to its transition-rich character
	function automatic logic [9:0] token(input logic [1:0] c);
		unique case (c)
			2'h0: return dtrd_pkg::TOK_00;
			2'h1: return dtrd_pkg::TOK_01;
			2'h2: return dtrd_pkg::TOK_10;
			2'h3: return dtrd_pkg::TOK_11;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Pixel timing
	// ---------------------------------------------------------------
	// One pixel period holds ten bits of four cycles each
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cyc <= 6'h00;
			bit_idx <= 4'h0;
			bit_cyc <= 2'h0;
		end else begin
			cyc <= (cyc == LAST_CYC) ? 6'h00 : 6'(cyc + 6'h01);
			bit_cyc <= 2'(bit_cyc + 2'h1);
			if (cyc == LAST_CYC) begin
				bit_idx <= 4'h0;
			end else if (bit_cyc == 2'h3) begin
				bit_idx <= 4'(bit_idx + 4'h1);
			end
		end
	end

	// Reference clock high in the first half of each pixel period
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link.input_reference_clock <= 1'b0;
		end else begin
			link.input_reference_clock <= (cyc == LAST_CYC) || (cyc < HALF_CYC - 6'h01);
		end
	end

	// ---------------------------------------------------------------
	// Blanking guard and encoding
	// ---------------------------------------------------------------
	// A short blank is stretched so the receiver can always realign
	assign eff_de = i_de && (de_sent || blank_cnt >= BLANK_MIN);

	always_comb begin
		for (int l = 0; l < 3; l++) begin
			enc[l] = encode(i_pixel_rgb[8*l +: 8], disp[l]);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			de_sent <= 1'b0;
			blank_cnt <= 8'h00;
			o_take <= 1'b0;
			for (int l = 0; l < 3; l++) begin
				chr[l] <= dtrd_pkg::TOK_00;
				disp[l] <= 5'sd0;
			end
		end else begin
			o_take <= (cyc == LAST_CYC - 6'h01);
			if (cyc == LAST_CYC) begin
				de_sent <= eff_de;
				if (eff_de) begin
					blank_cnt <= 8'h00;
					for (int l = 0; l < 3; l++) begin
						chr[l] <= enc[l][9:0];
						disp[l] <= enc[l][14:10];
					end
				end else begin
					if (blank_cnt < BLANK_MIN) begin
						blank_cnt <= 8'(blank_cnt + 8'h01);
					end
					chr[0] <= token({i_vsync, i_hsync});
					chr[1] <= token(i_user_control_bits[1:0]);
					chr[2] <= token(i_user_control_bits[3:2]);
					for (int l = 0; l < 3; l++) begin
						disp[l] <= 5'sd0;
					end
				end
			end
		end
	end

	// Serial lanes, least significant bit first
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link.blue_lane_input <= 1'b0;
			link.green_lane_input <= 1'b0;
			link.red_lane_input <= 1'b0;
		end else begin
			link.blue_lane_input <= chr[0][bit_idx];
			link.green_lane_input <= chr[1][bit_idx];
			link.red_lane_input <= chr[2][bit_idx];
		end
	end
endmodule
`default_nettype wire

//--- verilog/dtrd_rx_end.sv
// Receiving end: oversampled lane alignment, character decode, sync detect
`timescale 1ns/100ps
`default_nettype none
module dtrd_rx_end #(
	parameter int IDLE_PIX = dtrd_pkg::IDLE_PIX, // Idle pixels before link loss
	parameter int ACQ_PIX = dtrd_pkg::ACQ_PIX // Window for two DE changes
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic i_dual_pixel, // 1: two pixels per output clock
	dtrd_link_if.rx link, // Serial link
	output logic o_output_pixel_clock, // Output pixel clock
	output logic [23:0] o_even_pixel_bus, // Even (or only) pixel
	output logic [23:0] o_odd_pixel_bus, // Odd pixel in dual mode
	output logic o_de, // Active display
	output logic o_hsync, // Horizontal sync
	output logic o_vsync, // Vertical sync
	output logic [3:1] o_user_control_bits, // User control bits 3..1
	output logic o_sync_detect_flag // Link active
);
	logic [2:0] lane_raw;
	logic [2:0] lane_m;
	logic [2:0] lane_s;
	logic [2:0] lane_prev;
	logic ref_m;
	logic [1:0] ref_s;
	logic pix_stb;
	logic [1:0] ph [3];
	logic [1:0] edge_ph [3];
	logic [9:0] sr [3];
	logic [3:0] bit_cnt [3];
	logic [2:0] locked;
	logic [9:0] chr [3];
	logic [9:0] sr_next [3];
	logic [2:0] sample_now;
	logic de_now;
	logic de_prev;
	logic de_edge;
	logic sd_fall;
	logic [19:0] idle_cnt;
	logic [10:0] win_cnt;
	logic win_open;
	logic dual_slot;
	logic [23:0] even_hold;
	logic dual_m;
	logic dual_s;
	logic [1:0] pair0;
	logic [1:0] pair1;
	logic [1:0] pair2;

	// A character with many transitions marks blanking and a boundary
	function automatic logic is_token(input logic [9:0] c);
		return c == dtrd_pkg::TOK_00 || c == dtrd_pkg::TOK_01 ||
			c == dtrd_pkg::TOK_10 || c == dtrd_pkg::TOK_11;
	endfunction

	// Control character back to its bit pair {c1, c0}
	function automatic logic [1:0] token_bits(input logic [9:0] c);
		logic [1:0] b;
		b = 2'h0;
		if (c == dtrd_pkg::TOK_01) begin
			b = 2'h1;
		end else if (c == dtrd_pkg::TOK_10) begin
			b = 2'h2;
		end else if (c == dtrd_pkg::TOK_11) begin
			b = 2'h3;
		end
		return b;
	endfunction

	// Undo the inversion and the xor or xnor chain
	function automatic logic [7:0] decode(input logic [9:0] c);
		logic [7:0] d;
		logic [7:0] o;
		d = c[9] ? ~c[7:0] : c[7:0];
		o[0] = d[0];
		for (int i = 1; i < 8; i++) begin
			o[i] = c[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
		end
		return o;
	endfunction

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	assign lane_raw = {link.red_lane_input, link.green_lane_input, link.blue_lane_input};

	// Lanes, reference clock and mode pin come from another domain: two flops first
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lane_m <= 3'h0;
			lane_s <= 3'h0;
			lane_prev <= 3'h0;
			ref_m <= 1'b0;
			ref_s <= 2'h0;
			dual_m <= 1'b0;
			dual_s <= 1'b0;
		end else begin
			lane_m <= lane_raw;
			lane_s <= lane_m;
			lane_prev <= lane_s;
			ref_m <= link.input_reference_clock;
			ref_s <= {ref_s[0], ref_m};
			dual_m <= i_dual_pixel;
			dual_s <= dual_m;
		end
	end

	// Rising reference edge marks each pixel period
	assign pix_stb = ref_s[0] && !ref_s[1];

	// ---------------------------------------------------------------
	// Per-lane bit and character alignment
	// ---------------------------------------------------------------
	// Four system cycles per bit give four sampling phases per lane
	always_comb begin
		for (int l = 0; l < 3; l++) begin
			sample_now[l] = (ph[l] == 2'(edge_ph[l] + 2'(dtrd_pkg::OVERSAMPLE / 2)));
			sr_next[l] = {lane_s[l], sr[l][9:1]};
		end
	end

	// Phase counters, edge phase capture and the deserializers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			locked <= 3'h0;
			for (int l = 0; l < 3; l++) begin
				ph[l] <= 2'h0;
				edge_ph[l] <= 2'h0;
				sr[l] <= 10'h000;
				bit_cnt[l] <= 4'h0;
				chr[l] <= dtrd_pkg::TOK_00;
			end
		end else begin
			// Loss clears the locks; a token found in the same cycle still wins
			if (sd_fall) begin
				locked <= 3'h0;
			end
			for (int l = 0; l < 3; l++) begin
				ph[l] <= 2'(ph[l] + 2'h1);
				// Sample midway between edges; frozen once locked
				if (!locked[l] && lane_s[l] != lane_prev[l]) begin
					edge_ph[l] <= ph[l];
				end
				if (sample_now[l]) begin
					sr[l] <= sr_next[l];
					if (!locked[l] && is_token(sr_next[l])) begin
						// Boundary found on a blanking character
						locked[l] <= 1'b1;
						bit_cnt[l] <= 4'h0;
						chr[l] <= sr_next[l];
					end else if (locked[l] && bit_cnt[l] == 4'(dtrd_pkg::BITS_PER_CHAR - 1)) begin
						// An unaligned lane hands over only the token it locks on, so no false DE
						bit_cnt[l] <= 4'h0;
						chr[l] <= sr_next[l];
					end else begin
						bit_cnt[l] <= 4'(bit_cnt[l] + 4'h1);
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Character classification and output stage
	// ---------------------------------------------------------------
	// Active display only when no lane carries a control character
	assign de_now = !(is_token(chr[0]) || is_token(chr[1]) || is_token(chr[2]));
	assign de_edge = pix_stb && (de_now != de_prev);

	// Control pairs {c1, c0} of each lane
	assign pair0 = token_bits(chr[0]);
	assign pair1 = token_bits(chr[1]);
	assign pair2 = token_bits(chr[2]);

	// Data and control outputs change on the pixel strobe only
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			de_prev <= 1'b0;
			o_de <= 1'b0;
			o_hsync <= 1'b0;
			o_vsync <= 1'b0;
			o_user_control_bits <= 3'h0;
			o_even_pixel_bus <= 24'h000000;
			o_odd_pixel_bus <= 24'h000000;
			even_hold <= 24'h000000;
			dual_slot <= 1'b0;
		end else if (pix_stb) begin
			de_prev <= de_now;
			o_de <= de_now;
			if (de_now) begin
				// Pixels; syncs and controls keep their blanking values
				if (dual_s && !dual_slot) begin
					even_hold <= {decode(chr[2]), decode(chr[1]), decode(chr[0])};
				end else if (dual_s) begin
					o_even_pixel_bus <= even_hold;
					o_odd_pixel_bus <= {decode(chr[2]), decode(chr[1]), decode(chr[0])};
				end else begin
					o_even_pixel_bus <= {decode(chr[2]), decode(chr[1]), decode(chr[0])};
				end
			end else begin
				// Control pairs; the lane one low bit is thrown away
				o_hsync <= pair0[0];
				o_vsync <= pair0[1];
				o_user_control_bits[3:2] <= pair2;
				o_user_control_bits[1] <= pair1[1];
			end
			dual_slot <= dual_s ? !dual_slot : 1'b0;
		end
	end

	// Clock follows the reference, or toggles per pixel in dual mode
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_output_pixel_clock <= 1'b0;
		end else if (dual_s) begin
			if (pix_stb) begin
				o_output_pixel_clock <= !dual_slot;
			end
		end else begin
			o_output_pixel_clock <= ref_s[1];
		end
	end

	// ---------------------------------------------------------------
	// Sync detect
	// ---------------------------------------------------------------
	assign sd_fall = pix_stb && o_sync_detect_flag && !de_edge &&
		(idle_cnt == 20'(IDLE_PIX - 1));

	// Counts are in pixel periods, so a stopped reference freezes them
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sync_detect_flag <= 1'b0;
			idle_cnt <= 20'h00000;
			win_cnt <= 11'h000;
			win_open <= 1'b0;
		end else if (pix_stb) begin
			if (de_edge) begin
				idle_cnt <= 20'h00000;
			end else if (idle_cnt != 20'(IDLE_PIX - 1)) begin
				idle_cnt <= 20'(idle_cnt + 20'h00001);
			end
			if (sd_fall) begin
				o_sync_detect_flag <= 1'b0;
				win_open <= 1'b0;
			end else if (!o_sync_detect_flag) begin
				if (de_edge && win_open) begin
					o_sync_detect_flag <= 1'b1;
					win_open <= 1'b0;
				end else if (de_edge) begin
					win_open <= 1'b1;
					win_cnt <= 11'h000;
				end else if (win_open && win_cnt == 11'(ACQ_PIX - 1)) begin
					win_open <= 1'b0;
				end else if (win_open) begin
					win_cnt <= 11'(win_cnt + 11'h001);
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/dtrd_link_monitor.sv
// Checker of the serial link wires between the two ends
`timescale 1ns/100ps
`default_nettype none
module dtrd_link_monitor (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Async reset, active low
	input wire logic input_reference_clock, // Pixel reference
	input wire logic red_lane_input, // Lane 2
	input wire logic green_lane_input, // Lane 1
	input wire logic blue_lane_input // Lane 0
);
	// ---------------------------------------------------------------
	// Short aliases
	// ---------------------------------------------------------------
	logic rc;
	logic rl;
	logic gl;
	logic bl;
	logic ref_warm;
	assign rc = input_reference_clock;
	assign rl = red_lane_input;
	assign gl = green_lane_input;
	assign bl = blue_lane_input;

	// First reference pulse after reset is one cycle short; judge shape after a fall
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_warm <= 1'b0;
		end else if ($fell(rc)) begin
			ref_warm <= 1'b1;
		end
	end

	// All wires belong to the system clock domain
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// ---------------------------------------------------------------
	// Reference clock shape: 40 cycle period, 20 high
	// ---------------------------------------------------------------
	a_ref_period: assert property (ref_warm && $rose(rc) |-> ##39 !rc ##1 rc)
		else $error("reference clock period wrong");
	a_ref_high_span: assert property (ref_warm && $rose(rc) |-> ##19 rc ##1 !rc)
		else $error("reference clock high time wrong");
	a_ref_low_hold: assert property ($fell(rc) |=> (!rc) [*8])
		else $error("reference clock low too short");
	a_ref_low_span: assert property ($rose(rc) |-> !$past(rc, 19))
		else $error("reference clock rose early");

	// ---------------------------------------------------------------
	// Each bit stands a tenth of the pixel period; red and blue lanes on one bit clock
	// ---------------------------------------------------------------
	a_red_bit_time: assert property ($changed(rl) |=> $stable(rl) [*3])
		else $error("red lane bit too short");
	a_green_bit_time: assert property ($changed(gl) |=> $stable(gl) [*3])
		else $error("green lane bit too short");
	a_blue_bit_time: assert property ($changed(bl) |=> $stable(bl) [*3])
		else $error("blue lane bit too short");
	a_lanes_one_clock: assert property ($changed(rl) |=> $stable(bl) [*3])
		else $error("lanes on different bit clocks");
endmodule
`default_nettype wire

//--- sim/dtrd_tb.sv
// Testbench joining transmitter and receiver ends over the link
`timescale 1ns/100ps
`default_nettype none
module dtrd_tb;
	logic i_clk_sys;
	logic i_rst_n;
	logic i_dual_pixel;
	logic [23:0] i_pixel_rgb;
	logic i_de;
	logic i_hsync;
	logic i_vsync;
	logic [3:0] i_user_control_bits;
	logic o_take;
	logic o_output_pixel_clock;
	logic [23:0] o_even_pixel_bus;
	logic [23:0] o_odd_pixel_bus;
	logic o_de;
	logic o_hsync;
	logic o_vsync;
	logic [3:1] o_user_control_bits;
	logic o_sync_detect_flag;
	int errors;
	int samples_checked;
	int c;
	// Blanking controls {vsync, hsync, user bits 3..0}: every token on lanes 0 and 1, all but token 10 on lane 2
	logic [5:0] bt [4] = '{6'h1E, 6'h25, 6'h00, 6'h3F};
	logic [23:0] pv [8] = '{24'hFF0000, 24'h00FF00, 24'h0000FF, 24'h000000,
		24'hFFFFFF, 24'h5AA55A, 24'h123456, 24'hEDCBA9};

	dtrd_link_if link ();

	dtrd_tx_end dtrd_tx_end_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_pixel_rgb(i_pixel_rgb), .i_de(i_de), .i_hsync(i_hsync), .i_vsync(i_vsync),
		.i_user_control_bits(i_user_control_bits), .o_take(o_take), .link(link));

	// Short idle limit keeps the link loss case inside a brief run
	dtrd_rx_end #(.IDLE_PIX(200), .ACQ_PIX(1600)) dtrd_rx_end_i (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_dual_pixel(i_dual_pixel), .link(link),
		.o_output_pixel_clock(o_output_pixel_clock), .o_even_pixel_bus(o_even_pixel_bus),
		.o_odd_pixel_bus(o_odd_pixel_bus), .o_de(o_de), .o_hsync(o_hsync),
		.o_vsync(o_vsync), .o_user_control_bits(o_user_control_bits),
		.o_sync_detect_flag(o_sync_detect_flag));

	dtrd_link_monitor dtrd_link_monitor_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.input_reference_clock(link.input_reference_clock),
		.red_lane_input(link.red_lane_input), .green_lane_input(link.green_lane_input),
		.blue_lane_input(link.blue_lane_input));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task test_done;
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One pixel per o_take; inputs set at the falling edge, taken at the next rise
	task send(input logic [23:0] rgb, input logic de, input logic [5:0] cv, input int n);
		int k;
		for (int p = 0; p < n; p++) begin
			k = 0;
			@(negedge i_clk_sys);
			while (o_take !== 1'b1 && k < 100) begin
				@(negedge i_clk_sys);
				k++;
			end
			i_pixel_rgb = rgb;
			i_de = de;
			{i_vsync, i_hsync, i_user_control_bits} = cv;
		end
	endtask

	// Token 00 must appear on all lanes, bit 0 first, while blanking with zeros
	task wire_tok;
		logic [9:0] sr [3];
		int hits;
		hits = 0;
		sr = '{10'h000, 10'h000, 10'h000};
		repeat (80) begin
			repeat (4) @(negedge i_clk_sys);
			sr[0] = {link.blue_lane_input, sr[0][9:1]};
			sr[1] = {link.green_lane_input, sr[1][9:1]};
			sr[2] = {link.red_lane_input, sr[2][9:1]};
			if (sr[0] === dtrd_pkg::TOK_00 && sr[1] === dtrd_pkg::TOK_00
				&& sr[2] === dtrd_pkg::TOK_00) hits++;
		end
		check({23'h000000, hits != 0}, 24'h000001);
	endtask

	task ck_rise(output int n);
		logic p;
		n = 0;
		do begin
			p = o_output_pixel_clock;
			@(negedge i_clk_sys);
			n++;
		end while (!(p === 1'b0 && o_output_pixel_clock === 1'b1) && n < 200);
	endtask

	// Eight active pixels sent while the receiver's stream is compared mid-pixel
	task burst(input logic [23:0] m);
		int k;
		fork
			for (int i = 0; i < 8; i++) send(pv[i] ^ m, 1'b1, 6'h00, 1);
			begin
				k = 0;
				while (o_de !== 1'b1 && k < 3000) begin
					@(negedge i_clk_sys);
					k++;
				end
				repeat (20) @(negedge i_clk_sys);
				for (int i = 0; i < 8; i++) begin
					check(o_even_pixel_bus, pv[i] ^ m);
					check(o_odd_pixel_bus, 24'h000000);
					check({18'h0, o_de, o_vsync, o_hsync, o_user_control_bits}, 24'h00003F);
					repeat (40) @(negedge i_clk_sys);
				end
			end
		join
	endtask

	// ---------------------------------------------------------------
	// Clock, reset and watchdog
	// ---------------------------------------------------------------
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	// About 600 pixels of traffic are expected; twice that is a hang
	initial begin
		#200000;
		errors++;
		test_done;
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		errors = 0;
		samples_checked = 0;
		i_rst_n = 1'b0;
		i_pixel_rgb = 24'h000000;
		i_de = 1'b0;
		i_dual_pixel = 1'b0;
		{i_vsync, i_hsync, i_user_control_bits} = 6'h00;
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_rst_n = 1'b1;
		for (int j = 0; j < 4; j++) begin
			send(24'h000000, 1'b0, bt[j], (j == 0) ? 150 : 8);
			check({19'h0, o_vsync, o_hsync, o_user_control_bits}, {19'h0, bt[j][5:1]});
			check({23'h0, o_de}, 24'h000000);
			if (j == 2) wire_tok;
		end
		check({23'h0, o_sync_detect_flag}, 24'h000000);
		ck_rise(c);
		ck_rise(c);
		check(24'(c), 24'h000028);
		burst(24'h000000);
		send(24'h000000, 1'b0, 6'h3F, 130);
		check({23'h0, o_sync_detect_flag}, 24'h000001);
		burst(24'hFFFFFF);
		send(24'h000000, 1'b0, 6'h3F, 230);
		check({23'h0, o_sync_detect_flag}, 24'h000000);
		// Two pixels per output clock; the first rises may straddle the switch
		i_dual_pixel = 1'b1;
		ck_rise(c);
		ck_rise(c);
		ck_rise(c);
		check(24'(c), 24'h000050);
		test_done;
	end
endmodule
`default_nettype wire
